/* File: verilog/pcl_program_counter.v */
// Purpose: Program counter sequencing and load logic for a small 8-bit core.
// Assumes: One operation per cycle, decoded by the instruction decoder.
// Notes:   Stack and decoder live outside; this block only forms addresses.
// What this block does
// - Program counter is a 15-bit register addressing program memory.
// - Low byte of counter is readable and writable as a data register.
// - Upper seven bits have no direct access; loaded from high latch, call operand or branch sums.
// - Any reset clears every counter bit to zero.
// - Writing the low byte also loads upper bits from latch together.
// - Computed jump adds offset to low byte; upper bits from latch, no carry.
// - Absolute call loads low byte and bits 2:0 from operand, 6:3 latch.
// - Indirect call loads low byte from accumulator, upper bits from latch.
// - Accumulator branch loads incremented address plus unsigned accumulator.
// - Literal branch loads incremented address plus sign-extended operand.
`timescale 1ns/1ns
`include "pcl_consts.vh"
module pcl_program_counter #(
   parameter PC_W = `PCL_PC_WIDTH
) (
   // Clock and reset
   input  wire            sys_clk,
   input  wire            reset,
   // Decoded operation and operands
   input  wire [2:0]      op_code,
   input  wire [7:0]      low_wr_data,
   input  wire [7:0]      accumulator,
   input  wire [10:0]     call_operand,
   input  wire [8:0]      branch_operand,
   // High latch write
   input  wire            latch_wr_en,
   input  wire [6:0]      latch_wr_data,
   // Counter and read-back
   output reg  [PC_W-1:0] program_counter,
   output reg  [7:0]      counter_low_byte_reg,
   output reg  [6:0]      counter_high_latch,
   // Return address to the stack
   output reg             push_valid,
   output reg  [PC_W-1:0] push_address
);
   wire [6:0]      latch_q;
   reg  [PC_W-1:0] pc_next;
   wire [PC_W-1:0] pc_incr;
   wire [7:0]      low_sum;
   wire [PC_W-1:0] acc_branch_target;
   wire [PC_W-1:0] lit_branch_target;
   wire            is_call;

   pcl_high_latch #(
      .WIDTH (`PCL_HIGH_WIDTH)
   ) pcl_high_latch_inst (
      .sys_clk (sys_clk),
      .reset   (reset),
      .wr_en   (latch_wr_en),
      .wr_data (latch_wr_data),
      .latch_q (latch_q)
   );

   // The counter still holds the current instruction's address when it executes; pc_incr is the next one.
   assign pc_incr           = program_counter + 15'h0001;
   // Eight-bit sum on purpose: the carry out of the low byte is dropped.
   assign low_sum           = program_counter[7:0] + low_wr_data;
   assign acc_branch_target = pc_incr + {7'h00, accumulator};
   assign lit_branch_target = pc_incr + {{6{branch_operand[8]}}, branch_operand};
   assign is_call           = (op_code == `PCL_OP_CALL) || (op_code == `PCL_OP_CALL_IND);

   always @* begin
      pc_next = program_counter;
      case (op_code)
         `PCL_OP_WRITE_LOW: begin
            pc_next = {latch_q, low_wr_data};
         end
         `PCL_OP_ADD_LOW: begin
            pc_next = {latch_q, low_sum};
         end
         `PCL_OP_CALL: begin
            pc_next = {latch_q[6:3], call_operand};
         end
         `PCL_OP_CALL_IND: begin
            pc_next = {latch_q, accumulator};
         end
         `PCL_OP_ACC_BRANCH: begin
            pc_next = acc_branch_target;
         end
         `PCL_OP_LIT_BRANCH: begin
            pc_next = lit_branch_target;
         end
         `PCL_OP_INCR: begin
            pc_next = pc_incr;
         end
         default: begin
            pc_next = program_counter;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         program_counter      <= `PCL_PC_RESET;
         counter_low_byte_reg <= `PCL_LOW_RESET;
         counter_high_latch   <= `PCL_LATCH_RESET;
         push_valid           <= 1'b0;
         push_address         <= `PCL_PC_RESET;
      end else begin
         program_counter      <= pc_next;
         counter_low_byte_reg <= pc_next[7:0];
         counter_high_latch   <= latch_q;
         push_valid           <= is_call;
         push_address         <= is_call ? pc_incr : push_address;
      end
   end
endmodule // pcl_program_counter

/* File: verilog/pcl_consts.vh */
// Purpose: Constants for the program counter load logic.
// Assumes: Included by bare name from design files.
// Notes:   Definitions only.
`ifndef PCL_CONSTS_VH
`define PCL_CONSTS_VH
`define PCL_PC_WIDTH      15
`define PCL_LOW_WIDTH     8
`define PCL_HIGH_WIDTH    7
`define PCL_CALL_WIDTH    11
`define PCL_BRANCH_WIDTH  9
`define PCL_PC_RESET      15'h0000
`define PCL_LOW_RESET     8'h00
`define PCL_LATCH_RESET   7'h00
`define PCL_OP_NONE       3'h0
`define PCL_OP_WRITE_LOW  3'h1
`define PCL_OP_ADD_LOW    3'h2
`define PCL_OP_CALL       3'h3
`define PCL_OP_CALL_IND   3'h4
`define PCL_OP_ACC_BRANCH 3'h5
`define PCL_OP_LIT_BRANCH 3'h6
`define PCL_OP_INCR       3'h7
`endif

/* File: verilog/pcl_high_latch.v */
// Purpose: High-latch register that stages the upper program counter bits.
// Assumes: Written by the core data path on the same clock.
// Notes:   Value is used as a source for the upper counter bits and for read-back.
`timescale 1ns/1ns
`include "pcl_consts.vh"
module pcl_high_latch #(
   parameter WIDTH = `PCL_HIGH_WIDTH
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             reset,
   // Write port
   input  wire             wr_en,
   input  wire [WIDTH-1:0] wr_data,
   // Latched value
   output reg  [WIDTH-1:0] latch_q
);
   always @(posedge sys_clk) begin
      if (reset) begin
         latch_q <= `PCL_LATCH_RESET;
      end else if (wr_en) begin
         latch_q <= wr_data;
      end
   end
endmodule // pcl_high_latch

/* File: dv/pcl_acc_model.sv */
// Purpose: Working register model.
// Assumes: Loaded a cycle ahead of use.
// Notes: Holds its value between loads.
`timescale 1ns/1ns
module pcl_acc_model(input logic sys_clk,ld,output logic [7:0] accumulator=8'h0);
   always @(posedge sys_clk) if (ld) accumulator<=8'hf0;
endmodule // pcl_acc_model

/* File: dv/pcl_pc_chk.sv */
// Purpose: Counter port checks.
// Assumes: Sees only the counter ports and keeps its own copy of the latch.
// Notes: Operands are held one cycle.
`timescale 1ns/1ns
module pcl_pc_chk(input logic sys_clk,reset,push_valid,latch_wr_en,input logic [2:0] op_code,
   input logic [7:0] accumulator,low_wr_data,counter_low_byte_reg,
   input logic [8:0] branch_operand,input logic [10:0] call_operand,
   input logic [6:0] counter_high_latch,latch_wr_data,
   input logic [14:0] program_counter,push_address);
   logic r;
   logic [2:0] o;
   logic [6:0] m,t;
   logic [7:0] a,w,s;
   logic [10:0] c;
   logic [14:0] b,n;
   // An op sees the latch as it stood before its edge, not a write at that edge.
   always @(posedge sys_clk) m<=reset?7'h0:latch_wr_en?latch_wr_data:m;
   always @(posedge sys_clk) {r,o,t,a,w,s}<={reset,reset?3'h0:op_code,reset?7'h0:m,accumulator,
      low_wr_data,8'(program_counter[7:0]+low_wr_data)};
   always @(posedge sys_clk) {c,b,n}<={call_operand,{6{branch_operand[8]}},branch_operand,
      program_counter+15'h1};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_RS: assert property(r|->program_counter==15'h0&&!push_valid)else $error("rs");
   AST_WR: assert property(o==3'h1|->program_counter=={t,w})else $error("wr");
   AST_AD: assert property(o==3'h2|->program_counter=={t,s})else $error("ad");
   AST_CA: assert property(o==3'h3|->program_counter=={t[6:3],c})else $error("ca");
   AST_CI: assert property(o==3'h4|->program_counter=={t,a})else $error("ci");
   AST_LO: assert property(counter_low_byte_reg==program_counter[7:0])else $error("lo");
   AST_HL: assert property(counter_high_latch==t)else $error("hl");
   AST_PU: assert property(o inside{3'h3,3'h4}|->push_valid&&push_address==n)
      else $error("pu");
   AST_BW: assert property(o==3'h5|->program_counter==n+a)else $error("bw");
   AST_BA: assert property(o==3'h6|->program_counter==n+b)else $error("ba");
endmodule // pcl_pc_chk
bind pcl_program_counter pcl_pc_chk pcl_pc_chk_inst(.*);

/* File: dv/program_counter_load_logic_tb.sv */
// Purpose: Self-checking counter bench.
// Assumes: Inputs move 1 ns after an edge.
// Notes: Table rows, then latch and reset cases.
`timescale 1ns/1ns
module program_counter_load_logic_tb;
   logic sys_clk=0,reset=1,we=0,pv;
   logic [2:0] op=0;
   logic [10:0] d=0;
   logic [6:0] wd=7'h2a,hl;
   logic [7:0] acc,lo;
   logic [14:0] pc,pa;
   int errors=0,compares=0;
   logic [28:0] rows[7]='{{3'h1,11'h10,15'h2a10},{3'h2,11'hf5,15'h2a05},{3'h3,11'h7ff,15'h2fff},
      {3'h5,11'h0,15'h30f0},{3'h6,11'h100,15'h2ff1},{3'h4,11'h0,15'h2af0},{3'h7,11'h0,15'h2af1}};
   always #10 sys_clk=~sys_clk;
   pcl_acc_model pcl_acc_model_inst(.sys_clk,.ld(we),.accumulator(acc));
   pcl_program_counter pcl_program_counter_inst(.sys_clk,.reset,.op_code(op),.low_wr_data(d[7:0]),
      .accumulator(acc),.call_operand(d),.branch_operand(d[8:0]),.latch_wr_en(we),.latch_wr_data(wd),
      .program_counter(pc),.counter_low_byte_reg(lo),.counter_high_latch(hl),.push_valid(pv),
      .push_address(pa));
   task chk(input logic [14:0] s,e);
      compares++;
      errors+=(s!==e);
      if (s!==e) $display("CHECK FAILED %0t got %h want %h",$time,s,e);
   endtask
   task tally_and_finish;
      $display("errors %0d compares %0d",errors,compares);
      if (errors==0&&compares>0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task st(input logic [2:0] o,input logic [10:0] v);
      op=o;
      d=v;
      @(posedge sys_clk) #1;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      #1 reset=0;
      st(3'h0,11'h0);
      we=1;
      st(3'h0,11'h0);
      we=0;
      foreach (rows[i]) begin
         st(rows[i][28:26],rows[i][25:15]);
         chk(pc,rows[i][14:0]);
         chk({7'h0,lo},{7'h0,rows[i][7:0]});
      end
      we=1;
      wd=7'h7f;
      st(3'h1,11'h33);
      chk(pc,15'h2a33);
      we=0;
      st(3'h3,11'h1);
      chk(pa,15'h2a34);
      chk({14'h0,pv},15'h1);
      chk({7'h0,lo},15'h1);
      chk(pc,15'h7801);
      chk({8'h0,hl},15'h7f);
      st(3'h4,11'h0);
      chk(pa,15'h7802);
      chk(pc,15'h7ff0);
      st(3'h5,11'h0);
      chk(pc,15'he1);
      chk({14'h0,pv},15'h0);
      reset=1;
      st(3'h7,11'h0);
      chk(pc,15'h0);
      chk({14'h0,pv},15'h0);
      reset=0;
      st(3'h1,11'h44);
      chk(pc,15'h44);
      chk({8'h0,hl},15'h0);
      tally_and_finish;
   end
   initial begin
      #2000;
      errors++;
      tally_and_finish;
   end
endmodule // program_counter_load_logic_tb
